// *** phase_sequencer.sv ***
// start-up and run-time phase sequencer of the acceleration sensor
// assumes ADC samples and sync pulses are synchronous to CLK_I
`timescale 1ns/100ps
module phase_sequencer
	import selftest_seq_pkg::*;
#(
	parameter int FRAME_CYCLES = FRAME_CYC,
	parameter int FAST_UPDATE_CYCLES = int'(FAST_UPDATE_CYC),
	parameter int SLOW_UPDATE_CYCLES = int'(SLOW_UPDATE_CYC),
	parameter logic [9:0] RANGE_CODE = 10'h210,
	parameter logic [9:0] DELIM_CODE = 10'h200,
	parameter logic [9:0] OFFSET_LIMIT = 10'h040
) (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic ADC_VALID_I,
	input wire logic signed [9:0] ADC_DATA_I,
	input wire logic INTERNAL_SELFTEST_SELECT_I,
	input wire logic FORMAT_SELECT_HIGH_I,
	input wire logic FORMAT_SELECT_LOW_I,
	input wire logic AUTOZERO_EN_I,
	input wire logic STATE_VECTOR_EN_I,
	input wire logic TEN_BIT_I,
	input wire logic SYNC_MODE_I,
	input wire logic SYNC_PULSE_I,
	input wire logic OTP_PARITY_ERR_I,
	input wire logic signed [9:0] OFFSET_MIN_I,
	input wire logic signed [9:0] OFFSET_MAX_I,
	input wire logic signed [9:0] RESPONSE_MIN_I,
	input wire logic signed [9:0] RESPONSE_MAX_I,
	input wire logic TX_READY_I,
	output frame_t TX_FRAME_O,
	output logic TX_VALID_O,
	output logic STIMULUS_FORCE_CONTROL_O,
	output phase_t PHASE_O,
	output logic SELFTEST_ERROR_O,
	output logic signed [9:0] OFFSET_CORRECTION_O
);
	phase_t phase_q;
	step_t step_q;
	logic [6:0] smp_cnt_q;
	logic [2:0] cyc_q;
	logic [1:0] pass_q;
	logic ev_q;
	logic signed [9:0] samp_q;
	logic signed [9:0] z1_q;
	logic signed [9:0] p_q;
	logic signed [9:0] z2_q;
	logic signed [9:0] mean;
	logic avg_done;
	logic avg_add;
	logic pass;
	logic [1:0] pass_sum;
	logic [1:0] err_kind_q;
	logic [13:0] frame_cnt_q;
	logic pend_q;
	logic rng_tgl_q;
	logic [15:0] az_cnt_q;
	logic signed [17:0] filt_q;
	logic [27:0] upd_cnt_q;
	logic upd_now;
	logic fifo_ready;
	logic fifo_valid;
	frame_t fifo_data;
	frame_t push_frame;
	logic sent;
	logic out_load;
	logic signed [10:0] diff_sp;
	logic signed [10:0] diff_zz;
	logic signed [10:0] corr;
	logic signed [9:0] accel;

	// ==========================================================
	// sample capture and averaging
	// only qualified samples are counted or averaged
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			samp_q <= '0;
		end else if (ADC_VALID_I) begin
			samp_q <= ADC_DATA_I;
		end
	end

	assign avg_add = ADC_VALID_I && phase_q == PH_SELFTEST && step_q != STEP_EVAL
		&& smp_cnt_q >= SKIP_SAMPLES;

	sample_averager u_avg (
		.clk_i(CLK_I),
		.resetn_i(RESETN_I),
		.clear_i(ADC_VALID_I && smp_cnt_q == 7'h00),
		.add_i(avg_add),
		.last_i(smp_cnt_q == LAST_SAMPLE),
		.sample_i(ADC_DATA_I),
		.done_o(avg_done),
		.mean_o(mean)
	);

	// ==========================================================
	// cycle checks; the zero delta is taken in full 10-bit counts
	always_comb begin
		diff_sp = 11'(p_q) - 11'(z1_q);
		diff_zz = 11'(z1_q) - 11'(z2_q);
		if (diff_zz < 0) begin
			diff_zz = -diff_zz;
		end
		pass = z1_q >= OFFSET_MIN_I && z1_q <= OFFSET_MAX_I
			&& z2_q >= OFFSET_MIN_I && z2_q <= OFFSET_MAX_I
			&& diff_sp >= 11'(RESPONSE_MIN_I) && diff_sp <= 11'(RESPONSE_MAX_I)
			&& diff_zz <= 11'(ZERO_DELTA_MAX);
		pass_sum = pass_q + 2'(pass);
	end

	// step walk: skip 32, average 64, three times, then evaluate
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			step_q <= STEP_ZERO1;
			smp_cnt_q <= '0;
		end else if (phase_q != PH_SELFTEST) begin
			step_q <= STEP_ZERO1;
			smp_cnt_q <= '0;
		end else if (ev_q) begin
			step_q <= STEP_ZERO1;
		end else if (ADC_VALID_I && step_q != STEP_EVAL) begin
			if (smp_cnt_q == LAST_SAMPLE) begin
				smp_cnt_q <= '0;
				case (step_q)
					STEP_ZERO1: step_q <= STEP_STIM;
					STEP_STIM: step_q <= STEP_ZERO2;
					STEP_ZERO2: step_q <= STEP_EVAL;
					default: step_q <= STEP_ZERO1;
				endcase
			end else begin
				smp_cnt_q <= smp_cnt_q + 7'h01;
			end
		end
	end

	// stimulus is on for the whole stimulated step, once per cycle
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			STIMULUS_FORCE_CONTROL_O <= 1'b0;
		end else begin
			STIMULUS_FORCE_CONTROL_O <= phase_q == PH_SELFTEST && step_q == STEP_STIM
				&& !(ADC_VALID_I && smp_cnt_q == LAST_SAMPLE);
		end
	end

	// averages land one cycle after the step has already moved on
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			z1_q <= '0;
			p_q <= '0;
			z2_q <= '0;
			ev_q <= 1'b0;
		end else begin
			ev_q <= avg_done && step_q == STEP_EVAL;
			if (avg_done) begin
				case (step_q)
					STEP_STIM: z1_q <= mean;
					STEP_ZERO2: p_q <= mean;
					STEP_EVAL: z2_q <= mean;
					default: z1_q <= z1_q;
				endcase
			end
		end
	end

	// ==========================================================
	// phase machine; only reset leaves the error phase
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			phase_q <= PH_SELFTEST;
			cyc_q <= '0;
			pass_q <= '0;
			err_kind_q <= 2'h0;
			SELFTEST_ERROR_O <= 1'b0;
		end else begin
			case (phase_q)
				PH_SELFTEST: begin
					if (ev_q) begin
						cyc_q <= cyc_q + 3'h1;
						if (!INTERNAL_SELFTEST_SELECT_I) begin
							// external mode never judges itself
							if (cyc_q + 3'h1 == MAX_CYCLES) begin
								phase_q <= PH_AZINIT;
							end
						end else if (pass_sum == NEEDED_PASSES) begin
							phase_q <= PH_AZINIT;
						end else if (cyc_q + 3'h1 == MAX_CYCLES) begin
							phase_q <= PH_ERROR;
							err_kind_q <= 2'h1;
							SELFTEST_ERROR_O <= 1'b1;
						end
						pass_q <= INTERNAL_SELFTEST_SELECT_I ? pass_sum : pass_q;
					end
				end
				PH_AZINIT: begin
					if (OTP_PARITY_ERR_I) begin
						phase_q <= PH_ERROR;
						err_kind_q <= 2'h3;
					end else if (!AUTOZERO_EN_I) begin
						phase_q <= PH_NORMAL;
					end else if (sent && az_cnt_q == AZ_SENDS_LAST) begin
						phase_q <= PH_NORMAL;
					end
				end
				PH_NORMAL: begin
					if (OTP_PARITY_ERR_I) begin
						phase_q <= PH_ERROR;
						err_kind_q <= 2'h3;
					end else if (upd_now && (OFFSET_CORRECTION_O > $signed(OFFSET_LIMIT)
						|| OFFSET_CORRECTION_O < -$signed(OFFSET_LIMIT))) begin
						phase_q <= PH_ERROR;
						err_kind_q <= 2'h2;
					end
				end
				PH_ERROR: phase_q <= PH_ERROR;
				default: phase_q <= PH_ERROR;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			PHASE_O <= PH_SELFTEST;
		end else begin
			PHASE_O <= phase_q;
		end
	end

	// ==========================================================
	// auto-zero: one-pole low-pass, slew-limited to one count per update
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			az_cnt_q <= '0;
		end else if (phase_q == PH_AZINIT && sent) begin
			az_cnt_q <= az_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			upd_cnt_q <= '0;
		end else if (upd_now || phase_q == PH_SELFTEST) begin
			upd_cnt_q <= '0;
		end else begin
			upd_cnt_q <= upd_cnt_q + 28'h0000001;
		end
	end

	// half second while initialising, five seconds afterwards
	assign upd_now = (phase_q == PH_AZINIT
		&& upd_cnt_q == 28'(FAST_UPDATE_CYCLES - 1))
		|| (phase_q == PH_NORMAL
		&& upd_cnt_q == 28'(SLOW_UPDATE_CYCLES - 1));

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			filt_q <= '0;
			OFFSET_CORRECTION_O <= '0;
		end else if (phase_q == PH_SELFTEST) begin
			// seed both filter and offset from the last zero average
			filt_q <= {z2_q, 8'h00};
			OFFSET_CORRECTION_O <= z2_q;
		end else if (AUTOZERO_EN_I && phase_q != PH_ERROR) begin
			if (ADC_VALID_I) begin
				filt_q <= filt_q + 18'(($signed({samp_q, 8'h00}) - filt_q)
					>>> (phase_q == PH_AZINIT ? FAST_SHIFT : SLOW_SHIFT));
			end
			// a bare part-select is unsigned; negative offsets would compare wrong
			if (upd_now && $signed(filt_q[17:FILT_FRAC]) > OFFSET_CORRECTION_O) begin
				OFFSET_CORRECTION_O <= OFFSET_CORRECTION_O + 10'sd1;
			end else if (upd_now && $signed(filt_q[17:FILT_FRAC]) < OFFSET_CORRECTION_O) begin
				OFFSET_CORRECTION_O <= OFFSET_CORRECTION_O - 10'sd1;
			end
		end
	end

	// ==========================================================
	// frame pacing: fixed period, or one frame per sync pulse
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			frame_cnt_q <= '0;
			pend_q <= 1'b0;
			rng_tgl_q <= 1'b0;
		end else begin
			if (SYNC_MODE_I || frame_cnt_q == 14'(FRAME_CYCLES - 1)) begin
				frame_cnt_q <= '0;
			end else begin
				frame_cnt_q <= frame_cnt_q + 14'h0001;
			end
			// a frame waits in pend_q while the buffer is full
			if ((SYNC_MODE_I && SYNC_PULSE_I)
				|| (!SYNC_MODE_I && frame_cnt_q == 14'(FRAME_CYCLES - 1))) begin
				pend_q <= 1'b1;
			end else if (sent) begin
				pend_q <= 1'b0;
			end
			if (sent) begin
				rng_tgl_q <= !rng_tgl_q;
			end
		end
	end

	assign sent = pend_q && fifo_ready;

	// frame content per phase
	always_comb begin
		corr = 11'(samp_q) - 11'(OFFSET_CORRECTION_O);
		if (corr > 11'(ACCEL_MAX)) begin
			corr = 11'(ACCEL_MAX);
		end else if (corr < -11'(ACCEL_MAX)) begin
			corr = -11'(ACCEL_MAX);
		end
		accel = (AUTOZERO_EN_I && phase_q != PH_SELFTEST) ? corr[9:0] : samp_q;
		push_frame.stim = STIMULUS_FORCE_CONTROL_O && STATE_VECTOR_EN_I;
		push_frame.word = TEN_BIT_I ? accel : {2'b00, accel[9:2]};
		if (phase_q == PH_SELFTEST && INTERNAL_SELFTEST_SELECT_I) begin
			case ({FORMAT_SELECT_HIGH_I, FORMAT_SELECT_LOW_I})
				2'b01: push_frame.word = rng_tgl_q ? DELIM_CODE : RANGE_CODE;
				2'b10: push_frame.word = DELIM_CODE;
				default: push_frame.word = TEN_BIT_I ? OK_CODE10 : {2'b00, OK_CODE8};
			endcase
		end else if (phase_q == PH_ERROR) begin
			if (!STATE_VECTOR_EN_I) begin
				push_frame.word = TEN_BIT_I ? ERR_CODE10 : {2'b00, ERR_CODE8};
			end else begin
				case (err_kind_q)
					2'h1: push_frame.word = TEN_BIT_I ? STERR_CODE10 : {2'b00, STERR_CODE8};
					2'h2: push_frame.word = TEN_BIT_I ? OFSERR_CODE10 : {2'b00, OFSERR_CODE8};
					default: push_frame.word = TEN_BIT_I ? OTPERR_CODE10 : {2'b00, OTPERR_CODE8};
				endcase
			end
		end
	end

	frame_fifo #(
		.WIDTH($bits(frame_t)),
		.DEPTH(32)
	) u_fifo (
		.clk_i(CLK_I),
		.resetn_i(RESETN_I),
		.in_valid_i(pend_q),
		.in_ready_o(fifo_ready),
		.in_data_i(push_frame),
		.out_valid_o(fifo_valid),
		.out_ready_i(out_load),
		.out_data_o(fifo_data)
	);

	// output register keeps the transmitter ports straight from flops
	assign out_load = !TX_VALID_O || TX_READY_I;

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			TX_VALID_O <= 1'b0;
			TX_FRAME_O <= '0;
		end else if (out_load) begin
			TX_VALID_O <= fifo_valid;
			// an empty buffer's read port shows unwritten storage; keep the last frame
			if (fifo_valid) begin
				TX_FRAME_O <= fifo_data;
			end
		end
	end

	// ==========================================================
	// assertions
	a_stim_in_step: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		STIMULUS_FORCE_CONTROL_O |-> $past(step_q) == STEP_STIM)
		else $error("stimulus outside stimulated step");
	a_error_sticky: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		phase_q == PH_ERROR |=> phase_q == PH_ERROR)
		else $error("error phase left without reset");
	a_az_skip: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		phase_q == PH_AZINIT && !AUTOZERO_EN_I && !OTP_PARITY_ERR_I |=> phase_q == PH_NORMAL)
		else $error("disabled auto-zero did not skip init");
	a_common_code: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		sent && phase_q == PH_ERROR && !STATE_VECTOR_EN_I && TEN_BIT_I
		|-> push_frame.word == ERR_CODE10)
		else $error("wrong common error code");
	a_two_passes: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		ev_q && phase_q == PH_SELFTEST && INTERNAL_SELFTEST_SELECT_I && pass_sum == 2'h2
		|=> phase_q == PH_AZINIT)
		else $error("second pass did not end self-test");
	a_fail_error: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		$rose(SELFTEST_ERROR_O) |-> pass_q < 2'h2 && cyc_q == 3'h6)
		else $error("self-test error with enough passes");
	a_cycle_cap: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		cyc_q <= 3'h6)
		else $error("more than six self-test cycles");
	a_az_length: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		phase_q == PH_AZINIT && AUTOZERO_EN_I && !OTP_PARITY_ERR_I ##1 phase_q == PH_NORMAL
		|-> az_cnt_q == 16'hFFFF)
		else $error("init ended at wrong send count");
	a_seed_offset: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		$past(phase_q) == PH_SELFTEST && phase_q == PH_AZINIT
		|-> OFFSET_CORRECTION_O == $past(z2_q))
		else $error("offset not seeded from last zero average");
	c_reach_normal: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		phase_q == PH_NORMAL && sent);
	c_reach_error: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		phase_q == PH_ERROR && sent);
	c_fail_then_pass: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		ev_q && !pass ##[1:1000] ev_q && pass);
	c_fifo_full: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		pend_q && !fifo_ready);
endmodule

// *** selftest_seq_pkg.sv ***
// constants, types and frame layout for the start-up phase sequencer
// assumes one 50 MHz clock and 10-bit two's complement ADC samples
package selftest_seq_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int FRAME_PERIOD_NS = 228000;
	localparam int FRAME_CYC = FRAME_PERIOD_NS / CLK_PERIOD_NS;
	localparam longint FAST_UPDATE_MS = 500;
	localparam longint SLOW_UPDATE_MS = 5000;
	localparam longint FAST_UPDATE_CYC = FAST_UPDATE_MS * 64'd1000000 / CLK_PERIOD_NS;
	localparam longint SLOW_UPDATE_CYC = SLOW_UPDATE_MS * 64'd1000000 / CLK_PERIOD_NS;

	// ==========================================================
	// self-test cycle shape and limits
	localparam logic [6:0] SKIP_SAMPLES = 7'h20;
	localparam logic [6:0] LAST_SAMPLE = 7'h5F;
	localparam int AVG_SHIFT = 6;
	localparam logic [2:0] MAX_CYCLES = 3'h6;
	localparam logic [1:0] NEEDED_PASSES = 2'h2;
	localparam logic [9:0] ZERO_DELTA_MAX = 10'h004;

	// ==========================================================
	// auto-zero
	localparam logic [15:0] AZ_SENDS_LAST = 16'hFFFE;
	localparam int FILT_FRAC = 8;
	localparam logic [4:0] FAST_SHIFT = 5'h08;
	localparam logic [4:0] SLOW_SHIFT = 5'h0B;
	localparam logic signed [9:0] ACCEL_MAX = 10'h1D0;

	// ==========================================================
	// transmitted codes
	localparam logic [9:0] OK_CODE10 = 10'h1E7;
	localparam logic [7:0] OK_CODE8 = 8'h7B;
	localparam logic [9:0] ERR_CODE10 = 10'h1F4;
	localparam logic [7:0] ERR_CODE8 = 8'h7D;
	localparam logic [9:0] STERR_CODE10 = 10'h1F7;
	localparam logic [7:0] STERR_CODE8 = 8'h7D;
	localparam logic [9:0] OFSERR_CODE10 = 10'h1F8;
	localparam logic [7:0] OFSERR_CODE8 = 8'h7E;
	localparam logic [9:0] OTPERR_CODE10 = 10'h1F6;
	localparam logic [7:0] OTPERR_CODE8 = 8'h7C;

	// ==========================================================
	// types
	typedef enum logic [3:0] {
		PH_SELFTEST = 4'h1,
		PH_AZINIT = 4'h2,
		PH_NORMAL = 4'h4,
		PH_ERROR = 4'h8
	} phase_t;

	typedef enum logic [3:0] {
		STEP_ZERO1 = 4'h1,
		STEP_STIM = 4'h2,
		STEP_ZERO2 = 4'h4,
		STEP_EVAL = 4'h8
	} step_t;

	typedef struct packed {
		logic stim;
		logic [9:0] word;
	} frame_t;

endpackage

// *** frame_fifo.sv ***
// first-in first-out buffer for outgoing frames
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/100ps
module frame_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 32
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// ==========================================================
	// handshakes; full and empty come from the fill count
	assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_q];

	// storage has no reset, only the pointers and fill count do
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_q] <= in_data_i;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// *** sample_averager.sv ***
// accumulates 64 signed samples and presents their mean
// assumes the caller clears it before the first sample of a window
`timescale 1ns/100ps
module sample_averager
	import selftest_seq_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic clear_i,
	input wire logic add_i,
	input wire logic last_i,
	input wire logic signed [9:0] sample_i,
	output logic done_o,
	output logic signed [9:0] mean_o
);
	logic signed [15:0] acc_q;

	// ==========================================================
	// sum of 64 ten-bit values fits 16 bits; mean is a plain shift
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			acc_q <= '0;
		end else if (clear_i) begin
			acc_q <= '0;
		end else if (add_i) begin
			acc_q <= acc_q + 16'(sample_i);
		end
	end

	// done marks the cycle the mean holds the whole window
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= add_i && last_i;
		end
	end

	assign mean_o = acc_q[AVG_SHIFT+9:AVG_SHIFT];
endmodule

// *** frame_sink.sv ***
// far-side model: transmitter and control module taking the outgoing frames
// assumes a valid/ready handshake clocked by the sequencer's own clock
`timescale 1ns/100ps
module frame_sink
	import selftest_seq_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic stall_i,
	input wire logic valid_i,
	input wire frame_t frame_i,
	output logic ready_o,
	output logic [15:0] count_o,
	output frame_t last_o
);
	// ==========================================================
	// ready moves on the falling edge so it never races the sampling edge
	initial ready_o = 1'b0;
	always @(negedge clk_i) begin
		ready_o <= resetn_i & ~stall_i;
	end

	// ==========================================================
	// every accepted word is counted and the last one kept; judging the response is left to the bench
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			count_o <= 16'h0000;
			last_o <= '0;
		end else if (valid_i && ready_o) begin
			count_o <= count_o + 16'h0001;
			last_o <= frame_i;
		end
	end
endmodule

// *** phase_sequencer_tb.sv ***
// self-checking bench for the phase sequencer with a frame sink at the far side
// assumes the short frame period parameter below; auto-zero init is never run to its end
`timescale 1ns/100ps
module phase_sequencer_tb;
	import selftest_seq_pkg::*;
	localparam int FC = 20;
	typedef struct packed {logic hi; logic lo; logic ten; logic [9:0] word;} row_t;
	logic clk = 1'b0, rstn = 1'b0, adc_v = 1'b0, sel = 1'b0, fhi = 1'b0, flo = 1'b0;
	logic az = 1'b0, sv = 1'b0, ten = 1'b1, sync_m = 1'b0, sync_p = 1'b0, otp = 1'b0;
	logic stall = 1'b0, rdy, tx_v, stim, st_err, stim_q = 1'b0, flip = 1'b0;
	logic signed [9:0] adc_d = 10'h000, ofs, base = 10'h000, lvl = 10'h000, drift = 10'h000;
	logic signed [9:0] ofs_lo = 10'h3F6, ofs_hi = 10'h00A, rsp_lo = 10'h032, rsp_hi = 10'h096;
	frame_t tx_f, last, f;
	phase_t ph;
	logic [15:0] cnt, c0;
	int err_count = 0, checks_done = 0, cycles = 0, rises = 0, nsamp = 0, gap = 0;
	row_t rows [5] = '{'{1'b0, 1'b0, 1'b1, OK_CODE10}, '{1'b1, 1'b1, 1'b1, OK_CODE10},
		'{1'b1, 1'b0, 1'b1, 10'h200}, '{1'b0, 1'b1, 1'b1, 10'h210},
		'{1'b0, 1'b0, 1'b0, {2'h0, OK_CODE8}}};
	logic [29:0] fails [5] = '{{10'h003, 10'h067, 10'h005}, {10'h003, 10'h003, 10'h000},
		{10'h014, 10'h078, 10'h000}, {10'h003, 10'h067, 10'h000}, {10'h003, 10'h067, 10'h000}};
	logic [19:0] lims [5] = '{{10'h3F6, 10'h096}, {10'h3F6, 10'h096}, {10'h3F6, 10'h096},
		{10'h3F6, 10'h05A}, {10'h004, 10'h096}};

	always #10 clk = ~clk;

	phase_sequencer #(.FRAME_CYCLES(FC), .FAST_UPDATE_CYCLES(50), .SLOW_UPDATE_CYCLES(100))
	phase_sequencer_i (.CLK_I(clk), .RESETN_I(rstn), .ADC_VALID_I(adc_v), .ADC_DATA_I(adc_d),
		.INTERNAL_SELFTEST_SELECT_I(sel), .FORMAT_SELECT_HIGH_I(fhi), .FORMAT_SELECT_LOW_I(flo),
		.AUTOZERO_EN_I(az), .STATE_VECTOR_EN_I(sv), .TEN_BIT_I(ten), .SYNC_MODE_I(sync_m),
		.SYNC_PULSE_I(sync_p), .OTP_PARITY_ERR_I(otp), .OFFSET_MIN_I(ofs_lo),
		.OFFSET_MAX_I(ofs_hi), .RESPONSE_MIN_I(rsp_lo), .RESPONSE_MAX_I(rsp_hi),
		.TX_READY_I(rdy), .TX_FRAME_O(tx_f), .TX_VALID_O(tx_v), .STIMULUS_FORCE_CONTROL_O(stim),
		.PHASE_O(ph), .SELFTEST_ERROR_O(st_err), .OFFSET_CORRECTION_O(ofs));

	frame_sink frame_sink_i (.clk_i(clk), .resetn_i(rstn), .stall_i(stall), .valid_i(tx_v),
		.frame_i(tx_f), .ready_o(rdy), .count_o(cnt), .last_o(last));

	// ==========================================================
	// adc stream: a sample every other cycle, idle gap after each 288th sample
	always @(negedge clk) begin
		adc_d <= stim ? lvl : base + (flip ? drift : 10'h000);
		if (!rstn || gap != 0) begin
			adc_v <= 1'b0;
			gap <= rstn ? gap - 1 : 0;
			if (!rstn) nsamp <= 0;
		end else if (adc_v) adc_v <= 1'b0;
		else begin
			adc_v <= 1'b1;
			nsamp <= nsamp + 1;
			if (nsamp % 288 == 287) gap <= 4;
		end
	end

	// stimulus pulses counted; zero level shifts by drift at each stimulus end
	always @(posedge clk) begin
		stim_q <= stim;
		cycles <= cycles + 1;
		if (!rstn) begin
			rises <= 0;
			flip <= 1'b0;
		end else if (stim && !stim_q) rises <= rises + 1;
		else if (!stim && stim_q) flip <= ~flip;
		// ceiling well above the roughly 28000 cycles the scenarios need
		if (cycles == 40000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ==========================================================
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// config is applied under reset; reset values are checked before release
	task automatic cfg(input logic s, input logic h, input logic l, input logic a, input logic v);
		@(negedge clk);
		rstn = 1'b0;
		{sel, fhi, flo, az, sv, otp} = {s, h, l, a, v, 1'b0};
		repeat (6) @(negedge clk);
		check({ph, tx_v, stim, st_err}, {PH_SELFTEST, 3'h0});
		check(ofs, 16'h0000);
		rstn = 1'b1;
	endtask

	task automatic get_frame();
		c0 = cnt;
		for (int i = 0; i < 400 && cnt == c0; i++) @(negedge clk);
		check(cnt != c0, 1'b1);
		f = last;
	endtask

	task automatic wait_phase(input phase_t p, input int lim);
		for (int i = 0; i < lim && ph !== p; i++) @(negedge clk);
		check(ph, p);
	endtask

	task automatic tally_and_finish();
		if (err_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================================
	initial begin
		// content sent during internal self-test, per format and word size
		for (int i = 0; i < 5; i++) begin
			ten = rows[i].ten;
			cfg(1'b1, rows[i].hi, rows[i].lo, 1'b0, 1'b0);
			get_frame();
			check(f.word, rows[i].word);
		end
		ten = 1'b1;
		// drift of five, no response, offset high, narrowed limits: six failed cycles
		for (int i = 0; i < 5; i++) begin
			{base, lvl, drift} = fails[i];
			{ofs_lo, rsp_hi} = lims[i];
			cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
			wait_phase(PH_ERROR, 6000);
			check(rises, 6);
			check(st_err, 1'b1);
			get_frame();
			get_frame();
			check(f.word, ERR_CODE10);
		end
		// drift of four passes twice, auto-zero off goes straight to normal
		{base, lvl, drift, ofs_lo, rsp_hi} = {10'h003, 10'h067, 10'h004, 10'h3F6, 10'h096};
		cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_phase(PH_NORMAL, 2500);
		check(rises, 2);
		get_frame();
		get_frame();
		check(f.word, 10'h003);
		// one frame per sync pulse
		sync_m = 1'b1;
		repeat (60) @(negedge clk);
		c0 = cnt;
		repeat (3) begin
			sync_p = 1'b1;
			@(negedge clk);
			sync_p = 1'b0;
			repeat (30) @(negedge clk);
		end
		check(cnt - c0, 3);
		// far side stalls while the buffer fills, then drains it
		sync_m = 1'b0;
		stall = 1'b1;
		repeat (40 * FC) @(negedge clk);
		check({tx_v, tx_f.word}, {1'b1, 10'h003});
		c0 = cnt;
		stall = 1'b0;
		repeat (200) @(negedge clk);
		check(cnt - c0 >= 16'd32, 1'b1);
		// external mode with state vector and auto-zero, then a parity fault in init
		{base, lvl, drift} = {10'h003, 10'h064, 10'h000};
		cfg(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		for (int i = 0; i < 3000 && !stim; i++) @(negedge clk);
		repeat (60) @(negedge clk);
		get_frame();
		check({f.stim, f.word}, {1'b1, 10'h064});
		wait_phase(PH_AZINIT, 8000);
		check(rises, 6);
		check(ofs, 16'h0003);
		repeat (3) get_frame();
		check(f.word, 10'h000);
		otp = 1'b1;
		wait_phase(PH_ERROR, 10);
		get_frame();
		get_frame();
		check(f.word, OTPERR_CODE10);
		// external mode, auto-zero off, zero level beyond the offset limit, 8-bit words
		{base, lvl, drift} = {10'h050, 10'h0B4, 10'h000};
		ten = 1'b0;
		cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		wait_phase(PH_ERROR, 4500);
		check(ofs, 16'h0050);
		check(st_err, 1'b0);
		get_frame();
		get_frame();
		check(f.word, {2'h0, OFSERR_CODE8});
		tally_and_finish();
	end
endmodule
